// *** anx_regs.sv ***
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1 - reserved bits read zero and writes to them are dropped
// R2 - expansion bit 4 shows parallel detection fault, reset zero
// R3 - expansion bit 3 shows partner next-page ability, reset zero
// R4 - expansion bit 2 always reads one: local side can send next pages
// R5 - bit 1 sets on a received page, clears on expansion read
// R6 - expansion bit 0 shows partner auto-negotiation ability, reset zero
// R7 - writable bit 15 asks partner for another next page, reset zero
// R8 - writable bit 13 selects message page, reset one
// R9 - writable bit 12 says local side will comply, reset zero
// R10 - read-only bit 11 is inverse of last exchanged toggle
// R11 - writable 11-bit code field resets to one, the null page
// R12 - code goes out as message or unformatted per bit 13
// R13 - summary register mirrors page flag; reading it does not clear
// R14 - writes to read-only fields leave hardware status unchanged
module anx_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire anx_pkg::anx_wb_req_t wbReq,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  input wire anx_pkg::anx_an_stat_t anStat,
  output var anx_pkg::anx_np_tx_t npTx,
  output logic irq
);

  // bus state
  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] rdData;

  // expansion status state
  logic fault_r;
  logic partnerNp_r;
  logic partnerAn_r;
  logic pageRx_r;
  logic pageRx_nxt;

  // next-page transmit state
  logic more_r;
  logic more_nxt;
  logic msg_r;
  logic msg_nxt;
  logic comply_r;
  logic comply_nxt;
  logic toggle_r;
  logic toggle_nxt;
  logic [10:0] code_r;
  logic [10:0] code_nxt;

  // interrupt state
  logic [1:0] istat_r;
  logic [1:0] istat_nxt;
  logic [1:0] imask_r;
  logic [1:0] imask_nxt;
  logic irq_r;

  // decoded request
  wire reqNew = wbReq.cyc && wbReq.stb && !ack_r;
  wire hitExp = anx_pkg::addrHit(wbReq.adr, anx_pkg::IDX_EXPANSION);
  wire hitNpt = anx_pkg::addrHit(wbReq.adr, anx_pkg::IDX_NEXT_PAGE);
  wire hitSum = anx_pkg::addrHit(wbReq.adr, anx_pkg::IDX_SUMMARY);
  wire hitIst = anx_pkg::addrHit(wbReq.adr, anx_pkg::IDX_IRQ_STATUS);
  wire hitMsk = anx_pkg::addrHit(wbReq.adr, anx_pkg::IDX_IRQ_MASK);
  wire rdExp = reqNew && !wbReq.we && hitExp;
  wire rdIst = reqNew && !wbReq.we && hitIst;
  wire wrNpt = reqNew && wbReq.we && hitNpt;
  wire wrMsk = reqNew && wbReq.we && hitMsk;
  wire wrLo = wbReq.sel[0];
  wire wrHi = wbReq.sel[1];

  // register images; reserved positions are hard zeros
  wire [15:0] expWord = {11'h000, fault_r, partnerNp_r, // see R1
                         anx_pkg::LOCAL_NP_CAPABLE, // see R4
                         pageRx_r, partnerAn_r};
  wire [15:0] nptWord = {more_r, 1'b0, msg_r, comply_r, // see R1
                         toggle_r, code_r};
  wire [15:0] sumWord = {7'h00, pageRx_r, 8'h00}; // see R13

  // read mux; unmapped addresses answer with zero
  assign rdData = hitExp ? {16'h0000, expWord} :
                  hitNpt ? {16'h0000, nptWord} :
                  hitSum ? {16'h0000, sumWord} :
                  hitIst ? {30'h00000000, istat_r} :
                  hitMsk ? {30'h00000000, imask_r} : 32'h00000000;

  // page flag: a new page in the same cycle as the clearing read wins
  assign pageRx_nxt = anStat.pageReceived || (pageRx_r && !rdExp); // see R5

  // only bits 15, 13, 12 and 10:0 are writable; 14 and 11 have no path
  assign more_nxt = (wrNpt && wrHi) ? wbReq.dat[anx_pkg::NPT_MORE_BIT]
                                    : more_r; // see R7
  assign msg_nxt = (wrNpt && wrHi) ? wbReq.dat[anx_pkg::NPT_MSG_BIT]
                                   : msg_r; // see R8
  assign comply_nxt = (wrNpt && wrHi) ? wbReq.dat[anx_pkg::NPT_COMPLY_BIT]
                                      : comply_r; // see R9
  assign code_nxt[10:8] = (wrNpt && wrHi) ? wbReq.dat[10:8]
                                          : code_r[10:8]; // see R11
  assign code_nxt[7:0] = (wrNpt && wrLo) ? wbReq.dat[7:0] : code_r[7:0];

  // toggle follows the arbitration logic, never the bus
  assign toggle_nxt = anStat.wordExchanged ? !anStat.exchangedToggle
                                           : toggle_r; // see R10, R14

  // sticky events; set wins over the read that clears
  wire faultRise = anStat.faultDetected && !fault_r;
  wire [1:0] events = {faultRise, anStat.pageReceived};
  assign istat_nxt = events | (istat_r & ~{2{rdIst}});
  assign imask_nxt = (wrMsk && wrLo) ? wbReq.dat[1:0] : imask_r;

  // bus answer: ack one cycle after the request is taken
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end
    else
    begin
      ack_r <= reqNew;
      dat_r <= reqNew ? rdData : 32'h00000000;
    end
  end

  // status mirrors; the bus has no write path into them
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      fault_r <= 1'b0;
      partnerNp_r <= 1'b0;
      partnerAn_r <= 1'b0;
      pageRx_r <= 1'b0;
    end
    else
    begin
      fault_r <= anStat.faultDetected; // see R2, R14
      partnerNp_r <= anStat.partnerNextPage; // see R3
      partnerAn_r <= anStat.partnerAutoneg; // see R6
      pageRx_r <= pageRx_nxt; // see R5
    end
  end

  // next-page transmit fields
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      more_r <= anx_pkg::NPT_MORE_RST;
      msg_r <= anx_pkg::NPT_MSG_RST;
      comply_r <= anx_pkg::NPT_COMPLY_RST;
      toggle_r <= anx_pkg::NPT_TOGGLE_RST;
      code_r <= anx_pkg::NPT_CODE_RST; // see R11
    end
    else
    begin
      more_r <= more_nxt;
      msg_r <= msg_nxt;
      comply_r <= comply_nxt;
      toggle_r <= toggle_nxt;
      code_r <= code_nxt;
    end
  end

  // interrupt status, mask and level output
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      istat_r <= 2'h0;
      imask_r <= anx_pkg::IRQ_MASK_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
      irq_r <= |(istat_nxt & imask_nxt);
    end
  end

  // outputs straight from flops; code meaning is set by msg_r
  assign wbAck = ack_r;
  assign wbDatOut = dat_r;
  assign irq = irq_r;
  assign npTx = '{morePages: more_r, messagePage: msg_r, // see R12
                  comply: comply_r, toggle: toggle_r, code: code_r};

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence expRead;
    reqNew && !wbReq.we && hitExp;
  endsequence

  AST_RSVD_ZERO: assert property ( // see R1
    expRead |=> wbDatOut[31:anx_pkg::EXP_RSVD_LSB] == 27'h0000000
                && wbDatOut[anx_pkg::EXP_LOCAL_NP_BIT])
    else $error("expansion reserved bits or next-page able wrong");

  AST_NPT_RSVD: assert property ( // see R1
    reqNew && !wbReq.we && hitNpt |=>
      !wbDatOut[anx_pkg::NPT_RSVD_BIT] && wbDatOut[31:16] == 16'h0000)
    else $error("next-page reserved bit read non-zero");

  AST_FAULT_SHOWN: assert property ( // see R2
    expRead |=> wbDatOut[anx_pkg::EXP_FAULT_BIT] == $past(fault_r)
                && fault_r == $past(anStat.faultDetected))
    else $error("fault bit does not track detection");

  // read data stands only in the ack cycle, so look there and nowhere later
  AST_PARTNER_BITS: assert property ( // see R3
    expRead |=> wbDatOut[anx_pkg::EXP_PARTNER_NP_BIT] == $past(partnerNp_r)
      && wbDatOut[anx_pkg::EXP_PARTNER_AN_BIT] == $past(partnerAn_r)
      && partnerNp_r == $past(anStat.partnerNextPage)
      && partnerAn_r == $past(anStat.partnerAutoneg))
    else $error("partner ability bits wrong");

  AST_PAGE_SET: assert property ( // see R5
    anStat.pageReceived |=> pageRx_r [*1] ##0 istat_r[anx_pkg::IRQ_PAGE_BIT])
    else $error("page event not latched");

  AST_PAGE_CLEAR: assert property ( // see R5
    rdExp && !anStat.pageReceived |=> !pageRx_r)
    else $error("expansion read did not clear page flag");

  AST_SUMMARY_KEEP: assert property ( // see R13
    reqNew && !wbReq.we && hitSum && pageRx_r |=>
      pageRx_r && wbDatOut[anx_pkg::SUM_PAGE_BIT])
    else $error("summary read disturbed page flag");

  AST_TOGGLE: assert property ( // see R10
    anStat.wordExchanged |=> npTx.toggle == !$past(anStat.exchangedToggle)
                             ##1 npTx.toggle == $past(npTx.toggle) ||
                             $past(anStat.wordExchanged))
    else $error("toggle not inverse of exchanged value");

  AST_NPT_WRITE: assert property ( // see R7, R8, R9, R11, R14
    wrNpt && wbReq.sel[1:0] == 2'h3 |=>
      npTx.morePages == $past(wbReq.dat[anx_pkg::NPT_MORE_BIT])
      && npTx.messagePage == $past(wbReq.dat[anx_pkg::NPT_MSG_BIT])
      && npTx.comply == $past(wbReq.dat[anx_pkg::NPT_COMPLY_BIT])
      && npTx.code == $past(wbReq.dat[10:0])
      && (npTx.toggle == $past(npTx.toggle) || $past(anStat.wordExchanged)))
    else $error("next-page write landed wrong");

  AST_RO_WRITE: assert property ( // see R14
    reqNew && wbReq.we && hitExp && !anStat.pageReceived |=>
      pageRx_r == $past(pageRx_r))
    else $error("write changed read-only status");

  AST_IRQ_LEVEL: assert property (
    ##1 irq == |(istat_r & imask_r))
    else $error("interrupt level disagrees with status and mask");

  AST_ACK_ONE: assert property (
    wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");

  AST_PAGE_WINS: assert property ( // see R5
    rdExp && anStat.pageReceived |=> pageRx_r)
    else $error("page event lost to a clearing read");

  AST_DAT_IDLE: assert property (
    !wbAck |-> wbDatOut == 32'h00000000)
    else $error("read data not zero outside the ack cycle");

  AST_FAULT_EVENT: assert property (
    faultRise |=> istat_r[anx_pkg::IRQ_FAULT_BIT])
    else $error("fault rising edge not latched");

  AST_ISTAT_CLEAR: assert property (
    rdIst && !anStat.pageReceived && !faultRise |=> istat_r == 2'h0)
    else $error("interrupt status read did not clear");

  AST_MASK_WRITE: assert property (
    wrMsk && wrLo |=> imask_r == $past(wbReq.dat[1:0]))
    else $error("mask write landed wrong");

  // a single-lane write must leave the other lane alone
  AST_LOW_LANE: assert property ( // see R11
    wrNpt && wbReq.sel[1:0] == 2'h1 |=>
      npTx.code[7:0] == $past(wbReq.dat[7:0])
      && npTx.code[10:8] == $past(npTx.code[10:8])
      && npTx.morePages == $past(npTx.morePages)
      && npTx.messagePage == $past(npTx.messagePage)
      && npTx.comply == $past(npTx.comply))
    else $error("low-lane write touched high-lane fields");

  AST_HIGH_LANE: assert property ( // see R7, R11
    wrNpt && wbReq.sel[1:0] == 2'h2 |=>
      npTx.code[7:0] == $past(npTx.code[7:0])
      && npTx.code[10:8] == $past(wbReq.dat[10:8])
      && npTx.morePages == $past(wbReq.dat[anx_pkg::NPT_MORE_BIT]))
    else $error("high-lane write landed wrong");

  COV_PAGE_CLEAR: cover property (anStat.pageReceived ##[1:8] expRead);
  COV_SET_WINS: cover property (rdExp && anStat.pageReceived);
  COV_FAULT_IRQ: cover property (faultRise && imask_r[anx_pkg::IRQ_FAULT_BIT]);
  COV_NPT_WRITE: cover property (wrNpt && wbReq.sel[1:0] == 2'h3);
  COV_IRQ: cover property (!irq ##1 irq);

endmodule // anx_regs
`default_nettype wire

// *** anx_pkg.sv ***
`default_nettype none
// shared constants and carriers for the expansion / next-page register pair
package anx_pkg;

  // register indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_EXPANSION = 8'h06;
  localparam logic [7:0] IDX_NEXT_PAGE = 8'h07;
  localparam logic [7:0] IDX_SUMMARY = 8'h10;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h12;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h13;

  // expansion status field positions
  localparam int EXP_FAULT_BIT = 4;
  localparam int EXP_PARTNER_NP_BIT = 3;
  localparam int EXP_LOCAL_NP_BIT = 2;
  localparam int EXP_PAGE_BIT = 1;
  localparam int EXP_PARTNER_AN_BIT = 0;
  localparam int EXP_RSVD_LSB = 5;

  // next-page transmit field positions
  localparam int NPT_MORE_BIT = 15;
  localparam int NPT_RSVD_BIT = 14;
  localparam int NPT_MSG_BIT = 13;
  localparam int NPT_COMPLY_BIT = 12;
  localparam int NPT_TOGGLE_BIT = 11;

  // summary status and interrupt field positions
  localparam int SUM_PAGE_BIT = 8;
  localparam int IRQ_PAGE_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;

  // reset values
  localparam logic NPT_MORE_RST = 1'b0;
  localparam logic NPT_MSG_RST = 1'b1;
  localparam logic NPT_COMPLY_RST = 1'b0;
  localparam logic NPT_TOGGLE_RST = 1'b0;
  localparam logic [10:0] NPT_CODE_RST = 11'h001;
  localparam logic LOCAL_NP_CAPABLE = 1'b1;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // classic wishbone request as seen by the slave
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } anx_wb_req_t;

  // status from the arbitration logic, same clock domain
  typedef struct packed {
    logic faultDetected;
    logic partnerNextPage;
    logic partnerAutoneg;
    logic pageReceived;
    logic wordExchanged;
    logic exchangedToggle;
  } anx_an_stat_t;

  // next-page fields handed to the arbitration logic
  typedef struct packed {
    logic morePages;
    logic messagePage;
    logic comply;
    logic toggle;
    logic [10:0] code;
  } anx_np_tx_t;

  // true when a byte address selects the register at a given index
  function automatic logic addrHit(input logic [7:0] adr,
                                   input logic [7:0] idx);
    addrHit = (adr == {idx[5:0], 2'b00});
  endfunction

endpackage
`default_nettype wire

// *** anx_arb_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// arbitration-side stand-in: drives the status group on clock edges
module anx_arb_model (
  input wire logic ref_clk,
  output var anx_pkg::anx_an_stat_t anStat
);
  initial anStat = '0;

  // levels are plain mirrors, so they move on one edge only
  task automatic setLevels(input logic f, input logic np, input logic an);
    @(posedge ref_clk);
    anStat.faultDetected <= f;
    anStat.partnerNextPage <= np;
    anStat.partnerAutoneg <= an;
  endtask

  // one-cycle event pulse, one per received page
  task automatic sendPage();
    @(posedge ref_clk);
    anStat.pageReceived <= 1'b1;
    @(posedge ref_clk);
    anStat.pageReceived <= 1'b0;
  endtask

  // toggle is only valid with the pulse; flip it after so stale use shows
  task automatic exchange(input logic tog);
    @(posedge ref_clk);
    anStat.wordExchanged <= 1'b1;
    anStat.exchangedToggle <= tog;
    @(posedge ref_clk);
    anStat.wordExchanged <= 1'b0;
    anStat.exchangedToggle <= ~tog;
  endtask
endmodule // anx_arb_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic ref_clk;
  logic rst;
  anx_pkg::anx_wb_req_t wbReq;
  logic [31:0] wbDatOut;
  logic wbAck;
  anx_pkg::anx_an_stat_t anStat;
  anx_pkg::anx_np_tx_t npTx;
  logic irq;
  int failures = 0;
  int checksDone = 0;
  logic [31:0] rows [4] = '{32'hffffb7ff, 32'h00000000, 32'h58001000,
                            32'h2abc22bc};

  anx_regs dut_u (.ref_clk(ref_clk), .rst(rst), .wbReq(wbReq),
    .wbDatOut(wbDatOut), .wbAck(wbAck), .anStat(anStat), .npTx(npTx),
    .irq(irq));
  anx_arb_model arb_u (.ref_clk(ref_clk), .anStat(anStat));

  // clock at 25 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checksDone++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle; ack and data are taken at the same edge
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [15:0] d, input logic [3:0] sel,
                      output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel,
               dat: {16'h0000, d}};
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 20);
    if (n >= 20)
      chk("ack", 32'h1, 32'h0);
    rd = wbDatOut;
    wbReq <= '0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [15:0] d,
                    input logic [3:0] sel);
    logic [31:0] rd;
    xfer(1'b1, adr, d, sel, rd);
  endtask

  task automatic rdChk(input logic [7:0] adr, input logic [31:0] e);
    logic [31:0] rd;
    xfer(1'b0, adr, 16'h0000, 4'h3, rd);
    chk($sformatf("reg %h", adr), e, rd);
  endtask

  // expected transmit fields follow the register image with reserved bit 14 dropped
  function automatic logic [31:0] npOf(input logic [15:0] r);
    npOf = {17'h0, r[15], r[13], r[12], r[11], r[10:0]};
  endfunction

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    wbReq = '0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rdChk(8'h18, 32'h0004);
    rdChk(8'h1c, 32'h2001);
    chk("npTx", npOf(16'h2001), {17'h0, npTx});
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h1c, rows[i][31:16], 4'h3);
      rdChk(8'h1c, {16'h0, rows[i][15:0]});
      chk("npTx", npOf(rows[i][15:0]), {17'h0, npTx});
    end
    // disabled byte lanes and read-only targets must change nothing
    wr(8'h1c, 16'h0000, 4'h0);
    rdChk(8'h1c, 32'h22bc);
    wr(8'h18, 16'hffff, 4'h3);
    rdChk(8'h18, 32'h0004);
    rdChk(8'h7c, 32'h0000);
    arb_u.setLevels(1'b1, 1'b1, 1'b1);
    rdChk(8'h18, 32'h001d);
    arb_u.setLevels(1'b0, 1'b0, 1'b0);
    rdChk(8'h18, 32'h0004);
    // page flag: summary copy survives its own read, expansion read clears
    arb_u.sendPage();
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    rdChk(8'h40, 32'h0100);
    rdChk(8'h40, 32'h0100);
    wr(8'h4c, 16'h0001, 4'h3);
    chk("irq", 32'h1, {31'h0, irq});
    rdChk(8'h18, 32'h0006);
    rdChk(8'h18, 32'h0004);
    rdChk(8'h40, 32'h0000);
    rdChk(8'h48, 32'h0003);
    chk("irq", 32'h0, {31'h0, irq});
    // fault rising edge raises the interrupt once its mask bit is on
    wr(8'h4c, 16'h0002, 4'h3);
    rdChk(8'h4c, 32'h0002);
    arb_u.setLevels(1'b1, 1'b0, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'h1, {31'h0, irq});
    rdChk(8'h48, 32'h0002);
    chk("irq", 32'h0, {31'h0, irq});
    arb_u.setLevels(1'b0, 1'b0, 1'b0);
    // page event at the very edge that takes a clearing read: set wins
    fork
      arb_u.sendPage();
      rdChk(8'h18, 32'h0004);
    join
    rdChk(8'h18, 32'h0006);
    fork
      arb_u.sendPage();
      rdChk(8'h48, 32'h0001);
    join
    rdChk(8'h48, 32'h0001);
    rdChk(8'h48, 32'h0000);
    rdChk(8'h18, 32'h0006);
    arb_u.exchange(1'b1);
    rdChk(8'h1c, 32'h22bc);
    arb_u.exchange(1'b0);
    rdChk(8'h1c, 32'h2abc);
    chk("npTx", npOf(16'h2abc), {17'h0, npTx});
    // a second reset in mid-run restores the null page
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    rdChk(8'h1c, 32'h2001);
    chk("npTx", npOf(16'h2001), {17'h0, npTx});
    chk("irq", 32'h0, {31'h0, irq});
    rdChk(8'h4c, 32'h0000);
    // each byte lane alone touches only its own bits
    wr(8'h1c, 16'hffa5, 4'h1);
    rdChk(8'h1c, 32'h20a5);
    wr(8'h1c, 16'hffff, 4'h2);
    rdChk(8'h1c, 32'hb7a5);
    chk("npTx", npOf(16'hb7a5), {17'h0, npTx});
    finish_test();
  end
endmodule // testbench
`default_nettype wire
